// >>> hpcr_regs.sv
/*
 * hpcr_regs: configuration register bank of a two-downstream-port hub:
 * charge enables, drive boost, D+/D- swap, port remap, attach/write protect.
 * assumes: the serial management slave engine sits on sys_clk_in and presents
 * one byte access per strobe; remap_mode_in and the core line drives come
 * from logic on the same clock.
 */
// Function
// - charge enable: bit 2 port 2, bit 1 port 1, others reserved
// - upstream boost bits 1:0: normal, +4, +8, +12 percent
// - downstream boost bits 3:2 set port 2 drive, same encoding
// - downstream boost bits 1:0 set port 1 drive, bits 7:4 reserved
// - swap bits: 0 upstream, 1 port 1, 2 port 2, rest reserved
// - swap bit set routes D+ to DM pin and D- to DP pin
// - upper map nibble: 0001 logical 1, 0010 logical 2 for port 2
// - lower map nibble: 0000 disabled, 0001 logical 1, 0010 logical 2
// - map nibble codes 0011 to 1111 act as 0000
// - attach bit signals attach and blocks writes below ff until pin reset
// - soft reset bit restores defaults below ff and clears itself
`timescale 1ns/10ps
`default_nettype none

module hpcr_regs (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_en_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_en_in,
	output logic [7:0] reg_rdata_out,
	input wire logic remap_mode_in,
	input wire logic [2:0] core_dplus_in,
	input wire logic [2:0] core_dminus_in,
	output logic [2:0] pin_dp_out,
	output logic [2:0] pin_dm_out,
	output logic [1:0] charge_en_out,
	output logic [1:0] up_boost_out,
	output logic [1:0] dn1_boost_out,
	output logic [1:0] dn2_boost_out,
	output logic [2:0] swap_out,
	output logic [1:0] port1_logical_out,
	output logic [1:0] port2_logical_out,
	output logic usb_attach_out
);
	// ***********************
	// decode
	// ***********************
	function automatic logic [3:0] map_clean(input logic [3:0] code);
		map_clean = (code == hpcr_pkg::MAP_LOGICAL_1 || code == hpcr_pkg::MAP_LOGICAL_2) ?
			code : hpcr_pkg::MAP_DISABLED;
	endfunction

	function automatic logic [1:0] map_logical(input logic [3:0] code);
		map_logical = (code == hpcr_pkg::MAP_LOGICAL_1) ? hpcr_pkg::LOGICAL_ONE :
			(code == hpcr_pkg::MAP_LOGICAL_2) ? hpcr_pkg::LOGICAL_TWO : hpcr_pkg::LOGICAL_NONE;
	endfunction

	logic [1:0] charge_reg;
	logic [1:0] up_boost_reg;
	logic [3:0] dn_boost_reg;
	logic [2:0] swap_reg;
	logic [7:0] map_reg;
	logic attach_reg;
	logic soft_rst_reg;
	logic [2:0] pin_dp_reg;
	logic [2:0] pin_dm_reg;
	logic [7:0] rdata_reg;

	// everything below ff is locked once attached; ff itself stays open
	wire cfg_wr = reg_wr_en_in && !attach_reg && !soft_rst_reg;
	wire wr_charge = cfg_wr && reg_addr_in == hpcr_pkg::ADDR_CHARGE_EN;
	wire wr_up = cfg_wr && reg_addr_in == hpcr_pkg::ADDR_UP_BOOST;
	wire wr_dn = cfg_wr && reg_addr_in == hpcr_pkg::ADDR_DN_BOOST;
	wire wr_swap = cfg_wr && reg_addr_in == hpcr_pkg::ADDR_PIN_SWAP;
	wire wr_map = cfg_wr && reg_addr_in == hpcr_pkg::ADDR_PORT_MAP;
	wire wr_cmd = reg_wr_en_in && reg_addr_in == hpcr_pkg::ADDR_STAT_CMD;

	wire [3:0] map_p1 = map_clean(map_reg[hpcr_pkg::MAP_P1_LSB +: 4]);
	wire [3:0] map_p2 = map_clean(map_reg[hpcr_pkg::MAP_P2_LSB +: 4]);
	wire [1:0] p2_identity = (map_p2 == hpcr_pkg::MAP_DISABLED) ? hpcr_pkg::LOGICAL_NONE :
		hpcr_pkg::LOGICAL_TWO;

	wire [7:0] rd_mux =
		(reg_addr_in == hpcr_pkg::ADDR_CHARGE_EN) ? {5'h00, charge_reg, 1'b0} :
		(reg_addr_in == hpcr_pkg::ADDR_UP_BOOST) ? {6'h00, up_boost_reg} :
		(reg_addr_in == hpcr_pkg::ADDR_DN_BOOST) ? {4'h0, dn_boost_reg} :
		(reg_addr_in == hpcr_pkg::ADDR_PIN_SWAP) ? {5'h00, swap_reg} :
		(reg_addr_in == hpcr_pkg::ADDR_PORT_MAP) ? map_reg :
		(reg_addr_in == hpcr_pkg::ADDR_STAT_CMD) ? {6'h00, soft_rst_reg, attach_reg} :
		hpcr_pkg::RESET_BYTE;

	// ***********************
	// configuration registers
	// ***********************
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in || soft_rst_reg) begin
			charge_reg <= 2'h0;
			up_boost_reg <= hpcr_pkg::BOOST_RESET;
			dn_boost_reg <= 4'h0;
			swap_reg <= 3'h0;
			map_reg <= hpcr_pkg::RESET_BYTE;
		end else begin
			if (wr_charge) begin
				charge_reg <= {reg_wdata_in[hpcr_pkg::CHARGE_P2_BIT], reg_wdata_in[hpcr_pkg::CHARGE_P1_BIT]};
			end
			if (wr_up) begin
				up_boost_reg <= reg_wdata_in[hpcr_pkg::UP_BOOST_LSB +: 2];
			end
			if (wr_dn) begin
				dn_boost_reg <= reg_wdata_in[3:0];
			end
			if (wr_swap) begin
				swap_reg <= reg_wdata_in[2:0];
			end
			if (wr_map) begin
				map_reg <= reg_wdata_in;
			end
		end
	end

	// ***********************
	// status and command
	// ***********************
	// attach only falls with the pin, so soft reset leaves it standing
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			attach_reg <= 1'b0;
			soft_rst_reg <= 1'b0;
		end else begin
			if (wr_cmd && reg_wdata_in[hpcr_pkg::CMD_ATTACH_BIT]) begin
				attach_reg <= 1'b1;
			end
			soft_rst_reg <= wr_cmd && reg_wdata_in[hpcr_pkg::CMD_SOFT_RST_BIT] && !soft_rst_reg;
		end
	end

	// ***********************
	// line routing and read data
	// ***********************
	genvar i;
	generate
		for (i = 0; i < hpcr_pkg::NUM_LINES; i++) begin : g_line
			always_ff @(posedge sys_clk_in) begin
				if (!reset_n_in) begin
					pin_dp_reg[i] <= 1'b0;
					pin_dm_reg[i] <= 1'b0;
				end else begin
					pin_dp_reg[i] <= swap_reg[i] ? core_dminus_in[i] : core_dplus_in[i];
					pin_dm_reg[i] <= swap_reg[i] ? core_dplus_in[i] : core_dminus_in[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			rdata_reg <= hpcr_pkg::RESET_BYTE;
		end else if (reg_rd_en_in) begin
			rdata_reg <= rd_mux;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign pin_dp_out = pin_dp_reg;
	assign pin_dm_out = pin_dm_reg;
	assign charge_en_out = charge_reg;
	assign up_boost_out = up_boost_reg;
	assign dn1_boost_out = dn_boost_reg[hpcr_pkg::DN1_BOOST_LSB +: 2];
	assign dn2_boost_out = dn_boost_reg[hpcr_pkg::DN2_BOOST_LSB +: 2];
	assign swap_out = swap_reg;
	assign port1_logical_out = remap_mode_in ? map_logical(map_p1) : hpcr_pkg::LOGICAL_ONE;
	assign port2_logical_out = remap_mode_in ? map_logical(map_p2) : p2_identity;
	assign usb_attach_out = attach_reg;

	// ***********************
	// checks
	// ***********************
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);

	chk_locked_writes: assert property (attach_reg && reg_wr_en_in && reg_addr_in == hpcr_pkg::ADDR_PIN_SWAP
		|=> $stable(swap_reg)) else $error("swap changed while protected");
	chk_attach_sticks: assert property ($rose(attach_reg) |=> attach_reg [*8])
		else $error("attach dropped");
	chk_soft_clear: assert property (soft_rst_reg |=> !soft_rst_reg && map_reg == 8'h00 && swap_reg == 3'h0
		&& charge_reg == 2'h0) else $error("soft reset incomplete");
	chk_soft_trigger: assert property (wr_cmd && reg_wdata_in[1] && !soft_rst_reg |=> soft_rst_reg)
		else $error("soft reset not taken");
	chk_swap_route: assert property (swap_reg[0] && $stable(swap_reg) |=> pin_dp_reg[0] == $past(core_dminus_in[0]))
		else $error("upstream swap wrong");
	chk_charge_write: assert property (wr_charge |=> charge_reg == $past({reg_wdata_in[2], reg_wdata_in[1]}))
		else $error("charge enable not stored");
	chk_boost_write: assert property (wr_dn |=> dn2_boost_out == $past(reg_wdata_in[3:2])
		&& dn1_boost_out == $past(reg_wdata_in[1:0])) else $error("boost not stored");
	chk_map_reserved: assert property (remap_mode_in && map_reg[3:0] > 4'h2 |-> port1_logical_out == 2'h0)
		else $error("reserved map code used");
	chk_map_identity: assert property (!remap_mode_in |-> port1_logical_out == 2'h1)
		else $error("identity map broken");
	chk_up_read: assert property (reg_rd_en_in && reg_addr_in == hpcr_pkg::ADDR_UP_BOOST
		|=> reg_rdata_out == {6'h00, $past(up_boost_reg)}) else $error("boost read wrong");

	// stores that must land, port 2 map decode, unswapped routing, and the lock on the map byte
	chk_swap_write: assert property (wr_swap |=> swap_reg == $past(reg_wdata_in[2:0]))
		else $error("swap not stored");
	chk_up_write: assert property (wr_up |=> up_boost_out == $past(reg_wdata_in[1:0]))
		else $error("upstream boost not stored");
	chk_map_p2_remap: assert property (remap_mode_in && map_reg[7:4] == 4'h1 |-> port2_logical_out == 2'h1)
		else $error("port 2 remap wrong");
	chk_map_p2_off: assert property (!remap_mode_in && (map_reg[7:4] == 4'h0 || map_reg[7:4] > 4'h2)
		|-> port2_logical_out == 2'h0) else $error("port 2 not disabled");
	chk_line_normal: assert property (!swap_reg[1] |=> pin_dm_reg[1] == $past(core_dminus_in[1]))
		else $error("port 1 normal routing wrong");
	chk_locked_map: assert property (attach_reg && !soft_rst_reg && reg_wr_en_in
		&& reg_addr_in == hpcr_pkg::ADDR_PORT_MAP |=> $stable(map_reg)) else $error("map changed while protected");

	cov_attach: cover property ($rose(attach_reg));
	cov_soft_reset: cover property (soft_rst_reg);
	cov_remap_two: cover property (remap_mode_in && port1_logical_out == 2'h2);
	cov_locked_try: cover property (attach_reg && reg_wr_en_in && reg_addr_in == hpcr_pkg::ADDR_PORT_MAP);
endmodule // hpcr_regs

`default_nettype wire

// >>> hpcr_pkg.sv
/*
 * hpcr_pkg: offsets, field positions, reset values and codes for the hub
 * port configuration register bank.
 * assumes: byte-wide register space addressed by an 8-bit offset.
 */
`default_nettype none

package hpcr_pkg;
	// ***********************
	// register offsets
	// ***********************
	localparam logic [7:0] ADDR_CHARGE_EN = 8'hd0;
	localparam logic [7:0] ADDR_UP_BOOST = 8'hf6;
	localparam logic [7:0] ADDR_DN_BOOST = 8'hf8;
	localparam logic [7:0] ADDR_PIN_SWAP = 8'hfa;
	localparam logic [7:0] ADDR_PORT_MAP = 8'hfb;
	localparam logic [7:0] ADDR_STAT_CMD = 8'hff;

	// ***********************
	// field positions
	// ***********************
	localparam int CHARGE_P1_BIT = 1;
	localparam int CHARGE_P2_BIT = 2;
	localparam int UP_BOOST_LSB = 0;
	localparam int DN1_BOOST_LSB = 0;
	localparam int DN2_BOOST_LSB = 2;
	localparam int SWAP_UP_BIT = 0;
	localparam int SWAP_P1_BIT = 1;
	localparam int SWAP_P2_BIT = 2;
	localparam int MAP_P1_LSB = 0;
	localparam int MAP_P2_LSB = 4;
	localparam int CMD_ATTACH_BIT = 0;
	localparam int CMD_SOFT_RST_BIT = 1;
	localparam int NUM_LINES = 3;

	// ***********************
	// reset values and codes
	// ***********************
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] BOOST_RESET = 2'h0;
	localparam logic [3:0] MAP_DISABLED = 4'h0;
	localparam logic [3:0] MAP_LOGICAL_1 = 4'h1;
	localparam logic [3:0] MAP_LOGICAL_2 = 4'h2;
	localparam logic [1:0] LOGICAL_NONE = 2'h0;
	localparam logic [1:0] LOGICAL_ONE = 2'h1;
	localparam logic [1:0] LOGICAL_TWO = 2'h2;
endpackage

`default_nettype wire

// >>> hpcr_host_model.sv
/* configuring host model: drives byte accesses into the register port.
   assumes: the bank samples strobes on the rising edge of sys_clk_in. */
`timescale 1ns/10ps
`default_nettype none
module hpcr_host_model (
	input wire logic sys_clk_in,
	input wire logic [7:0] reg_rdata_in,
	output logic [7:0] reg_addr_out,
	output logic reg_wr_en_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_rd_en_out
);
	initial begin
		reg_addr_out = 8'h00;
		reg_wr_en_out = 1'b0;
		reg_wdata_out = 8'h00;
		reg_rd_en_out = 1'b0;
	end
	// attach is just a write of bit 0 to 8'hff; later writes stay the caller's choice
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		reg_addr_out <= a;
		reg_wdata_out <= d;
		reg_wr_en_out <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_en_out <= 1'b0;
		// released data shows the inverse so stale bytes cannot pass
		reg_wdata_out <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_in);
		reg_addr_out <= a;
		reg_rd_en_out <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_en_out <= 1'b0;
		@(negedge sys_clk_in);
		d = reg_rdata_in;
	endtask
endmodule // hpcr_host_model
`default_nettype wire

// >>> tb_hpcr_regs.sv
/* testbench for the hub port configuration bank, one task per scenario.
   assumes: hpcr_host_model issues all register accesses. */
`timescale 1ns/10ps
`default_nettype none
module tb_hpcr_regs;
	logic clk = 1'b0, rst_n = 1'b0, remap = 1'b0;
	logic [2:0] dplus = 3'h0, dminus = 3'h0, dp, dm, swp;
	logic [7:0] addr, wdata, rdata;
	logic wr_en, rd_en, attach;
	logic [1:0] chg, upb, dn1, dn2, lg1, lg2;
	int fail_count = 0, checked = 0;
	hpcr_regs u_hpcr_regs (.sys_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wr_en_in(wr_en),
		.reg_wdata_in(wdata), .reg_rd_en_in(rd_en), .reg_rdata_out(rdata), .remap_mode_in(remap),
		.core_dplus_in(dplus), .core_dminus_in(dminus), .pin_dp_out(dp), .pin_dm_out(dm), .charge_en_out(chg),
		.up_boost_out(upb), .dn1_boost_out(dn1), .dn2_boost_out(dn2), .swap_out(swp),
		.port1_logical_out(lg1), .port2_logical_out(lg2), .usb_attach_out(attach));
	hpcr_host_model u_hpcr_host_model (.sys_clk_in(clk), .reg_rdata_in(rdata), .reg_addr_out(addr),
		.reg_wr_en_out(wr_en), .reg_wdata_out(wdata), .reg_rd_en_out(rd_en));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_hpcr_host_model.rd(a, d);
		chk(d, exp);
	endtask
	task automatic end_of_test;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic pin_reset;
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	task automatic t_defaults;
		rc(8'hd0, 8'h00);
		rc(8'hf8, 8'h00);
		rc(8'hf6, 8'h00);
		rc(8'hfa, 8'h00);
		rc(8'hfb, 8'h00);
		rc(8'h20, 8'h00);
		chk({2'h0, lg2, 2'h0, lg1}, 8'h01);
	endtask
	task automatic t_fields;
		logic [1:0] c;
		u_hpcr_host_model.wr(8'hd0, 8'hff);
		rc(8'hd0, 8'h06);
		chk({6'h0, chg}, 8'h03);
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			u_hpcr_host_model.wr(8'hf6, {6'h3f, c});
			rc(8'hf6, {6'h00, c});
			chk({6'h0, upb}, {6'h0, c});
			u_hpcr_host_model.wr(8'hf8, {4'hf, ~c, c});
			rc(8'hf8, {4'h0, ~c, c});
			chk({4'h0, dn2, dn1}, {4'h0, ~c, c});
		end
	endtask
	task automatic t_swap;
		@(posedge clk);
		dplus <= 3'b101;
		dminus <= 3'b010;
		u_hpcr_host_model.wr(8'hfa, 8'hff);
		rc(8'hfa, 8'h07);
		chk({2'h0, dp, dm}, 8'h15);
		chk({5'h0, swp}, 8'h07);
		u_hpcr_host_model.wr(8'hfa, 8'h05);
		rc(8'hfa, 8'h05);
		chk({2'h0, dp, dm}, 8'h07);
		chk({5'h0, swp}, 8'h05);
	endtask
	task automatic t_map;
		logic [3:0] n;
		logic [1:0] e;
		for (int m = 0; m < 2; m++) begin
			for (int i = 0; i < 16; i++) begin
				n = i[3:0];
				e = (n == 4'h1) ? 2'h1 : (n == 4'h2) ? 2'h2 : 2'h0;
				@(posedge clk) remap <= m[0];
				u_hpcr_host_model.wr(8'hfb, {n, n});
				rc(8'hfb, {n, n});
				if (m == 1)
					chk({2'h0, lg2, 2'h0, lg1}, {2'h0, e, 2'h0, e});
				else
					chk({2'h0, lg2, 2'h0, lg1}, {2'h0, (e == 2'h0) ? 2'h0 : 2'h2, 4'h1});
			end
		end
	endtask
	task automatic t_soft;
		u_hpcr_host_model.wr(8'hd0, 8'h06);
		u_hpcr_host_model.wr(8'hff, 8'h02);
		rc(8'hff, 8'h00);
		rc(8'hd0, 8'h00);
		rc(8'hfa, 8'h00);
		rc(8'hfb, 8'h00);
	endtask
	task automatic t_attach;
		u_hpcr_host_model.wr(8'hfa, 8'h01);
		u_hpcr_host_model.wr(8'hff, 8'h01);
		u_hpcr_host_model.wr(8'hfa, 8'h06);
		u_hpcr_host_model.wr(8'hfb, 8'h22);
		rc(8'hfa, 8'h01);
		rc(8'hfb, 8'h00);
		chk({7'h0, attach}, 8'h01);
		// ff stays open while attached; soft reset clears the bank but not attach
		u_hpcr_host_model.wr(8'hff, 8'h02);
		rc(8'hfa, 8'h00);
		chk({7'h0, attach}, 8'h01);
		pin_reset();
		u_hpcr_host_model.wr(8'hfa, 8'h03);
		rc(8'hfa, 8'h03);
		chk({7'h0, attach}, 8'h00);
	endtask
	initial begin
		// hang guard: the whole run needs far fewer cycles than this
		repeat (20000) @(posedge clk);
		fail_count++;
		end_of_test();
	end
	initial begin
		pin_reset();
		t_defaults();
		t_fields();
		t_swap();
		t_map();
		t_soft();
		t_attach();
		end_of_test();
	end
endmodule // tb_hpcr_regs
`default_nettype wire
